// file: hdl/relay_bank_map.svh
// register map, field positions, reset values and timing counts of the relay bank controller
// Contract
// - Drive 32 relay outputs, each independent, each either open or closed.
// - A command opens or closes one chosen relay, or all relays together.
// - Programmable delay between successive relay operations, 0 to 65535 ms.
// - Separately programmable dwell time that a closed relay stays closed.
// - Logical address comes from two hex switches; valid values 1 to 255.
// - Base address is 64 times logical address plus 49152, on 64-byte boundaries.
// - Halt switch on: control reset bit restores power-up state and all defaults.
// - Halt switch off: control reset bit is ignored, nothing happens.
// - Message lamp lights during a bus cycle, stretched to about 0.2 s.
// - Message lamp stays lit while accesses keep coming; each access restarts it.
// - One channel lamp per relay 00 to 31, lit exactly when closed.
// - Fail lamp lit exactly while the system-fail line is driven.
// - Single relay position readable, taken from a buffer sampling the drive signal.
// - Programmed delay and identification information are readable by the controller.
// - All relays open from power-on until a command closes one.
// - Bus slave decodes 16-bit addresses and moves 16-bit data only.
`ifndef RELAY_BANK_MAP_SVH
`define RELAY_BANK_MAP_SVH

// clock rate and derived timing
`define RB_CLK_KHZ 10000
`define RB_MS_TIME 1
`define RB_MS_CYCLES (`RB_MS_TIME * `RB_CLK_KHZ)
`define RB_LAMP_MS 200
`define RB_LAMP_CYCLES (`RB_LAMP_MS * `RB_CLK_KHZ)

// address decode
`define RB_BASE_OFFSET 16'hC000
`define RB_LA_NONE 8'h00

// register offsets inside the 64-byte window
`define RB_CTRL_OFS 6'h00
`define RB_STAT_OFS 6'h04
`define RB_CMD_OFS 6'h08
`define RB_DELAY_OFS 6'h0C
`define RB_DWELL_OFS 6'h10
`define RB_POS_OFS 6'h14
`define RB_STLO_OFS 6'h18
`define RB_STHI_OFS 6'h1C
`define RB_ID_OFS 6'h20

// field positions
`define RB_CTRL_RESET_BIT 0
`define RB_CTRL_HALT_BIT 1
`define RB_STAT_BUSY_BIT 0
`define RB_STAT_PEND_BIT 1
`define RB_STAT_ERR_BIT 2
`define RB_STAT_FAIL_BIT 3
`define RB_STAT_LINE_BIT 4
`define RB_CMD_CHAN_LSB 8
`define RB_CMD_ALL_BIT 13
`define RB_POS_STATE_BIT 15

// command characters
`define RB_OP_CLOSE 8'h43
`define RB_OP_OPEN 8'h4F

// reset values
`define RB_DELAY_RST 16'h0000
`define RB_DWELL_RST 16'h0000
`define RB_ID_RST 16'h5A01

`endif

// file: hdl/relay_bank_pkg.sv
// types shared by the relay bank controller
package relay_bank_pkg;
  typedef enum {ST_TEST, ST_IDLE, ST_DWELL, ST_DELAY} seq_state_e;
  typedef logic [31:0] mask_t;
  typedef logic [15:0] half_t;
  typedef logic [15:0] bus_addr_t;
  typedef logic [31:0] word_t;
endpackage

// file: hdl/relay_bank_controller.sv
// relay bank controller: apb register slave, operation sequencer, relay drive and lamps
`include "relay_bank_map.svh"

module relay_bank_controller #(
  parameter int unsigned MS_CYCLES = `RB_MS_CYCLES,
  parameter int unsigned LAMP_CYCLES = `RB_LAMP_CYCLES,
  parameter logic [15:0] ID_VALUE = `RB_ID_RST // arbitrary value
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire relay_bank_pkg::bus_addr_t paddr_in,
  input wire relay_bank_pkg::word_t pwdata_in,
  output relay_bank_pkg::word_t prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [3:0] la_msd_in,
  input wire logic [3:0] la_lsd_in,
  input wire logic halt_sw_in,
  input wire logic sysfail_inhibit_in,
  input wire logic sysfail_line_in,
  output logic sysfail_do_out,
  output logic sysfail_oe_n_out,
  output relay_bank_pkg::mask_t relay_drive_out,
  output relay_bank_pkg::mask_t channel_lamp_out,
  output logic msg_lamp_out,
  output logic fail_lamp_out
);
  import relay_bank_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (MS_CYCLES < 1) begin : g_bad_ms
    $error("MS_CYCLES must be at least one");
  end
  if (LAMP_CYCLES < 1) begin : g_bad_lamp
    $error("LAMP_CYCLES must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0] log_addr;
  bus_addr_t base_addr;
  logic hit;
  logic [5:0] ofs;
  logic access;
  logic setup;
  logic map_ok;
  logic is_cmd;
  logic stall;
  logic done;
  logic wr_done;
  half_t wdata;
  half_t rd_word;
  logic [7:0] cmd_op;
  logic cmd_valid;
  mask_t cmd_mask;

  seq_state_e state_ff, nxt_state;
  mask_t relay_ff, nxt_relay;
  mask_t readback_ff, nxt_readback;
  mask_t last_mask_ff, nxt_last_mask;
  half_t delay_ff, nxt_delay;
  half_t dwell_ff, nxt_dwell;
  half_t wait_ff, nxt_wait;
  logic [31:0] tick_ff, nxt_tick;
  logic pend_ff, nxt_pend;
  logic pend_close_ff, nxt_pend_close;
  mask_t pend_mask_ff, nxt_pend_mask;
  logic err_ff, nxt_err;
  logic [4:0] pos_sel_ff, nxt_pos_sel;
  logic soft_rst_ff, nxt_soft_rst;
  word_t prdata_ff, nxt_prdata;
  logic [31:0] lamp_cnt_ff, nxt_lamp_cnt;
  logic lamp_on_ff, nxt_lamp_on;
  logic fail_ff, nxt_fail;
  logic sf_oe_n_ff, nxt_sf_oe_n;
  logic fail_lamp_ff, nxt_fail_lamp;
  logic any_rst;

  ////////////////////////////////////////////////////////////////////////////
  // address decode and apb handshake
  assign log_addr = {la_msd_in, la_lsd_in};
  assign base_addr = {2'b00, log_addr, 6'h00} + `RB_BASE_OFFSET;
  assign hit = (log_addr != `RB_LA_NONE) && (paddr_in[15:6] == base_addr[15:6]);
  assign ofs = paddr_in[5:0];
  assign setup = psel_in && !penable_in;
  assign access = psel_in && penable_in;
  assign wdata = pwdata_in[15:0];
  assign cmd_op = wdata[7:0];
  assign cmd_valid = (cmd_op == `RB_OP_CLOSE) || (cmd_op == `RB_OP_OPEN);
  assign cmd_mask = wdata[`RB_CMD_ALL_BIT] ? '1 : (32'h0000_0001 << wdata[12:8]);
  assign is_cmd = hit && pwrite_in && (ofs == `RB_CMD_OFS);
  // a second command waits in the access phase until the queue slot frees
  assign stall = is_cmd && pend_ff;
  assign pready_out = ce_in && access && !stall;
  assign done = pready_out;
  assign pslverr_out = done && !(hit && map_ok);
  assign wr_done = done && pwrite_in && hit && map_ok;
  assign any_rst = rst_in || soft_rst_ff;

  // read mux and map check
  always_comb begin
    map_ok = 1'b1;
    rd_word = 16'h0000;
    if (ofs == `RB_CTRL_OFS) begin
      rd_word[`RB_CTRL_HALT_BIT] = halt_sw_in;
    end else if (ofs == `RB_STAT_OFS) begin
      rd_word[`RB_STAT_BUSY_BIT] = (state_ff != ST_IDLE);
      rd_word[`RB_STAT_PEND_BIT] = pend_ff;
      rd_word[`RB_STAT_ERR_BIT] = err_ff;
      rd_word[`RB_STAT_FAIL_BIT] = fail_ff;
      rd_word[`RB_STAT_LINE_BIT] = sysfail_line_in;
    end else if (ofs == `RB_CMD_OFS) begin
      rd_word = 16'h0000;
    end else if (ofs == `RB_DELAY_OFS) begin
      rd_word = delay_ff;
    end else if (ofs == `RB_DWELL_OFS) begin
      rd_word = dwell_ff;
    end else if (ofs == `RB_POS_OFS) begin
      rd_word[`RB_POS_STATE_BIT] = readback_ff[pos_sel_ff];
      rd_word[12:8] = pos_sel_ff;
    end else if (ofs == `RB_STLO_OFS) begin
      rd_word = readback_ff[15:0];
    end else if (ofs == `RB_STHI_OFS) begin
      rd_word = readback_ff[31:16];
    end else if (ofs == `RB_ID_OFS) begin
      rd_word = ID_VALUE;
    end else begin
      map_ok = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and operation sequencer, next values
  always_comb begin
    nxt_state = state_ff;
    nxt_relay = relay_ff;
    nxt_readback = relay_ff; // input buffer samples the drive signal
    nxt_last_mask = last_mask_ff;
    nxt_delay = delay_ff;
    nxt_dwell = dwell_ff;
    nxt_wait = wait_ff;
    nxt_tick = tick_ff;
    nxt_pend = pend_ff;
    nxt_pend_close = pend_close_ff;
    nxt_pend_mask = pend_mask_ff;
    nxt_err = err_ff;
    nxt_pos_sel = pos_sel_ff;
    nxt_soft_rst = 1'b0;
    nxt_prdata = prdata_ff;
    // read data is captured in the setup phase
    if (setup) begin
      nxt_prdata = {16'h0000, rd_word};
    end
    // sequencer
    case (state_ff)
      ST_TEST: begin
        if (readback_ff == relay_ff) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        nxt_tick = 32'h0000_0000;
        if (pend_ff) begin
          nxt_pend = 1'b0;
          nxt_last_mask = pend_mask_ff;
          if (pend_close_ff) begin
            nxt_relay = relay_ff | pend_mask_ff;
          end else begin
            nxt_relay = relay_ff & ~pend_mask_ff;
          end
          if (pend_close_ff && (dwell_ff != 16'h0000)) begin
            nxt_wait = dwell_ff;
            nxt_state = ST_DWELL;
          end else begin
            nxt_wait = delay_ff;
            nxt_state = ST_DELAY;
          end
        end
      end
      ST_DWELL, ST_DELAY: begin
        if (wait_ff == 16'h0000) begin
          nxt_tick = 32'h0000_0000;
          if (state_ff == ST_DWELL) begin
            nxt_relay = relay_ff & ~last_mask_ff; // dwell over, reopen
            nxt_wait = delay_ff;
            nxt_state = ST_DELAY;
          end else begin
            nxt_state = ST_IDLE;
          end
        end else if (tick_ff == 32'(MS_CYCLES - 1)) begin
          nxt_tick = 32'h0000_0000;
          nxt_wait = wait_ff - 16'h0001;
        end else begin
          nxt_tick = tick_ff + 32'h0000_0001;
        end
      end
      default: begin
        nxt_state = ST_TEST;
      end
    endcase
    // register writes
    if (wr_done) begin
      if (ofs == `RB_CTRL_OFS) begin
        nxt_soft_rst = wdata[`RB_CTRL_RESET_BIT] && halt_sw_in;
      end else if (ofs == `RB_STAT_OFS) begin
        if (wdata[`RB_STAT_ERR_BIT]) begin
          nxt_err = 1'b0;
        end
      end else if (ofs == `RB_CMD_OFS) begin
        if (cmd_valid) begin
          nxt_pend = 1'b1;
          nxt_pend_close = (cmd_op == `RB_OP_CLOSE);
          nxt_pend_mask = cmd_mask;
        end
      end else if (ofs == `RB_DELAY_OFS) begin
        nxt_delay = wdata;
      end else if (ofs == `RB_DWELL_OFS) begin
        nxt_dwell = wdata;
      end else if (ofs == `RB_POS_OFS) begin
        nxt_pos_sel = wdata[12:8];
      end
    end
    // an unknown command character sets the error flag, winning over a clear
    if (wr_done && is_cmd && !cmd_valid) begin
      nxt_err = 1'b1;
    end
  end

  // registers and operation sequencer, state
  always_ff @(posedge mclk_in) begin
    if (any_rst) begin
      state_ff <= ST_TEST;
      relay_ff <= '0;
      readback_ff <= '0;
      last_mask_ff <= '0;
      delay_ff <= `RB_DELAY_RST;
      dwell_ff <= `RB_DWELL_RST;
      wait_ff <= 16'h0000;
      tick_ff <= 32'h0000_0000;
      pend_ff <= 1'b0;
      pend_close_ff <= 1'b0;
      pend_mask_ff <= '0;
      err_ff <= 1'b0;
      pos_sel_ff <= 5'h00;
      soft_rst_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (ce_in) begin
      state_ff <= nxt_state;
      relay_ff <= nxt_relay;
      readback_ff <= nxt_readback;
      last_mask_ff <= nxt_last_mask;
      delay_ff <= nxt_delay;
      dwell_ff <= nxt_dwell;
      wait_ff <= nxt_wait;
      tick_ff <= nxt_tick;
      pend_ff <= nxt_pend;
      pend_close_ff <= nxt_pend_close;
      pend_mask_ff <= nxt_pend_mask;
      err_ff <= nxt_err;
      pos_sel_ff <= nxt_pos_sel;
      soft_rst_ff <= nxt_soft_rst;
      prdata_ff <= nxt_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // message lamp stretch and fail indication, next values
  always_comb begin
    nxt_lamp_cnt = lamp_cnt_ff;
    if (psel_in && hit) begin
      nxt_lamp_cnt = LAMP_CYCLES; // restart on every access
    end else if (lamp_cnt_ff != 32'h0000_0000) begin
      nxt_lamp_cnt = lamp_cnt_ff - 32'h0000_0001;
    end
    nxt_lamp_on = (nxt_lamp_cnt != 32'h0000_0000);
    nxt_fail = (state_ff == ST_TEST); // fail driven for the self-test cycle after any reset
    nxt_sf_oe_n = !(nxt_fail && !sysfail_inhibit_in);
    nxt_fail_lamp = !nxt_sf_oe_n;
  end

  // message lamp stretch and fail indication, state
  always_ff @(posedge mclk_in) begin
    if (any_rst) begin
      lamp_cnt_ff <= 32'h0000_0000;
      lamp_on_ff <= 1'b0;
      fail_ff <= 1'b1;
      sf_oe_n_ff <= 1'b1;
      fail_lamp_ff <= 1'b0;
    end else if (ce_in) begin
      lamp_cnt_ff <= nxt_lamp_cnt;
      lamp_on_ff <= nxt_lamp_on;
      fail_ff <= nxt_fail;
      sf_oe_n_ff <= nxt_sf_oe_n;
      fail_lamp_ff <= nxt_fail_lamp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata_out = prdata_ff;
  assign relay_drive_out = relay_ff;
  assign channel_lamp_out = relay_ff;
  assign msg_lamp_out = lamp_on_ff;
  assign sysfail_do_out = 1'b0; // open drain, pulls low only
  assign sysfail_oe_n_out = sf_oe_n_ff;
  assign fail_lamp_out = fail_lamp_ff;

endmodule

// file: testbench/relay_bank_props.sv
// port-level assertions for the relay bank controller
`include "relay_bank_map.svh"
module relay_bank_props #(
  parameter int unsigned LAMP_CYCLES = 2000000
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire relay_bank_pkg::bus_addr_t paddr_in,
  input wire relay_bank_pkg::word_t pwdata_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [3:0] la_msd_in,
  input wire logic [3:0] la_lsd_in,
  input wire logic halt_sw_in,
  input wire logic sysfail_inhibit_in,
  input wire logic sysfail_oe_n_out,
  input wire relay_bank_pkg::mask_t relay_drive_out,
  input wire relay_bank_pkg::mask_t channel_lamp_out,
  input wire logic msg_lamp_out,
  input wire logic fail_lamp_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import relay_bank_pkg::*;
  logic hit;
  logic [31:0] idle_ff;
  logic [31:0] nxt_idle;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////////
  // 64-byte window at C000 plus 64 times the switch value; zero never hits
  assign hit = ({la_msd_in, la_lsd_in} != 8'h00) && (paddr_in[15:6] == 10'h300 + {2'b00, la_msd_in, la_lsd_in});
  // cycles since this module was last addressed, saturating
  always_comb begin
    nxt_idle = idle_ff;
    if (psel_in && hit)
      nxt_idle = 32'h0;
    else if (idle_ff != 32'hFFFFFFFF)
      nxt_idle = idle_ff + 32'h1;
  end
  always_ff @(posedge mclk_in) begin
    if (rst_in)
      idle_ff <= 32'hFFFFFFFF;
    else
      idle_ff <= nxt_idle;
  end
  ////////////////////////////////////////////////////////////////
  // accepted write of the reset bit in the control register
  sequence ctrl_reset_write;
    psel_in && penable_in && pready_out && pwrite_in && hit && paddr_in[5:0] == `RB_CTRL_OFS && pwdata_in[0]
      && !sysfail_inhibit_in;
  endsequence
  chk_lamp_mirror: assert property (channel_lamp_out == relay_drive_out)
    else $error("channel lamps differ from relay drive");
  chk_fail_lamp: assert property (fail_lamp_out == !sysfail_oe_n_out)
    else $error("fail lamp differs from fail line drive");
  chk_open_after_reset: assert property ($fell(rst_in) |-> relay_drive_out == '0)
    else $error("relay closed after reset");
  chk_lamp_lights: assert property (psel_in && hit && !halt_sw_in |=> msg_lamp_out [*8])
    else $error("message lamp not held after access");
  chk_lamp_expires: assert property (idle_ff > LAMP_CYCLES + 2 |-> !msg_lamp_out)
    else $error("message lamp lit too long");
  chk_miss_refused: assert property (psel_in && penable_in && pready_out && !hit |-> pslverr_out)
    else $error("access outside window not refused");
  chk_halt_off_ignored: assert property (ctrl_reset_write ##0 !halt_sw_in |=> sysfail_oe_n_out [*4])
    else $error("reset bit acted with halt off");
  chk_halt_on_reset: assert property (ctrl_reset_write ##0 halt_sw_in |-> ##[1:4] (!sysfail_oe_n_out && relay_drive_out == '0))
    else $error("reset bit ignored with halt on");
endmodule
bind relay_bank_controller relay_bank_props #(.LAMP_CYCLES(LAMP_CYCLES)) props (.mclk_in(mclk_in), .rst_in(rst_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .la_msd_in(la_msd_in), .la_lsd_in(la_lsd_in),
  .halt_sw_in(halt_sw_in), .sysfail_inhibit_in(sysfail_inhibit_in), .sysfail_oe_n_out(sysfail_oe_n_out),
  .relay_drive_out(relay_drive_out), .channel_lamp_out(channel_lamp_out), .msg_lamp_out(msg_lamp_out),
  .fail_lamp_out(fail_lamp_out));

// file: testbench/system_controller_model.sv
// apb commander standing in for the system controller
module system_controller_model (
  input wire logic mclk_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  input wire relay_bank_pkg::word_t prdata_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output relay_bank_pkg::bus_addr_t paddr_out,
  output relay_bank_pkg::word_t pwdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import relay_bank_pkg::*;
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 16'h0000;
    pwdata_out = 32'h0;
  end
  // one transfer: setup, access held until pready, then release with inverted bus
  task automatic xfer(input logic wr, input bus_addr_t a, input word_t d, output word_t q, output logic e,
                      output logic hung);
    hung = 1'b1;
    q = 32'h0;
    e = 1'b0;
    @(posedge mclk_in);
    psel_out <= 1'b1; // setup phase: select with direction, address and write data
    pwrite_out <= wr;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge mclk_in);
    penable_out <= 1'b1;
    for (int n = 0; n < 400 && hung; n++) begin
      @(posedge mclk_in);
      if (pready_in === 1'b1) begin
        q = prdata_in;
        e = pslverr_in;
        hung = 1'b0;
      end
    end
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    paddr_out <= ~a;
    pwdata_out <= ~d;
  endtask
endmodule

// file: testbench/testbench.sv
// self-checking bench for the relay bank controller
`include "relay_bank_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import relay_bank_pkg::*;
  localparam int MS = 4;
  localparam int LAMP = 20;
  localparam bus_addr_t BASE = 16'hC280; // logical address 0A
  logic mclk, rst, halt, psel, penable, pwrite, rdy, err, oe_n, sdo, fail_lamp, msg_lamp, e, hung;
  logic [7:0] la;
  bus_addr_t paddr;
  word_t pwdata, prdata, q;
  mask_t relays, lamps, mask;
  int failures, tests_run, n, ch;
  system_controller_model ctl (.mclk_in(mclk), .pready_in(rdy), .pslverr_in(err), .prdata_in(prdata),
    .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata));
  relay_bank_controller #(.MS_CYCLES(MS), .LAMP_CYCLES(LAMP)) dut (.mclk_in(mclk), .rst_in(rst), .ce_in(1'b1),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(rdy), .pslverr_out(err), .la_msd_in(la[7:4]), .la_lsd_in(la[3:0]),
    .halt_sw_in(halt), .sysfail_inhibit_in(1'b0), .sysfail_line_in(oe_n ? 1'b1 : sdo), .sysfail_do_out(sdo),
    .sysfail_oe_n_out(oe_n), .relay_drive_out(relays), .channel_lamp_out(lamps), .msg_lamp_out(msg_lamp),
    .fail_lamp_out(fail_lamp));
  ////////////////////////////////////////////////////////////////
  task check(input string what, input word_t seen, input word_t exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // one bus transfer; a hang ends the run
  task acc(input logic w, input bus_addr_t a, input word_t d);
    ctl.xfer(w, a, d, q, e, hung);
    if (hung) begin
      failures++;
      tally_and_finish();
    end
  endtask
  task wr(input logic [5:0] ofs, input word_t d);
    acc(1'b1, BASE + {10'h0, ofs}, d);
    check("write_err", {31'h0, e}, 32'h0);
  endtask
  task rd(input logic [5:0] ofs, input word_t exp, input string nm);
    acc(1'b0, BASE + {10'h0, ofs}, 32'h0);
    check(nm, q, exp);
  endtask
  // bounded wait for one relay to reach a level, counting cycles
  task wait_bit(input int idx, input logic val);
    for (n = 0; n < 200 && relays[idx] !== val; n++)
      @(posedge mclk);
    if (n == 200) begin
      failures++;
      tally_and_finish();
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    rst = 1'b1;
    halt = 1'b0;
    la = 8'h0A;
    failures = 0;
    tests_run = 0;
    mask = 32'h0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    check("relays_reset", relays, 32'h0);
    rd(`RB_ID_OFS, {16'h0, `RB_ID_RST}, "id");
    rd(`RB_DELAY_OFS, 32'h0, "delay_reset");
    acc(1'b0, BASE + 16'h0040, 32'h0);
    check("miss_above", {31'h0, e}, 32'h1);
    acc(1'b0, BASE - 16'h0040, 32'h0);
    check("miss_below", {31'h0, e}, 32'h1);
    // close each relay in turn; earlier ones stay closed
    for (ch = 0; ch < 32; ch++) begin
      wr(`RB_CMD_OFS, {19'h0, ch[4:0], `RB_OP_CLOSE});
      wait_bit(ch, 1'b1);
      mask[ch] = 1'b1;
      check("relay_mask", relays, mask);
    end
    check("lamps", lamps, 32'hFFFFFFFF);
    rd(`RB_STHI_OFS, 32'hFFFF, "upper_half");
    wr(`RB_CMD_OFS, 32'h204F);
    wait_bit(31, 1'b0);
    check("open_all", relays, 32'h0);
    wr(`RB_POS_OFS, 32'h0500);
    rd(`RB_POS_OFS, 32'h0500, "pos_open");
    wr(`RB_CMD_OFS, 32'h2043);
    wait_bit(0, 1'b1);
    check("close_all", relays, 32'hFFFFFFFF);
    rd(`RB_POS_OFS, 32'h8500, "pos_closed");
    wr(`RB_CMD_OFS, 32'h204F);
    wait_bit(0, 1'b0);
    // second command waits out the programmed delay
    wr(`RB_DELAY_OFS, 32'h3);
    rd(`RB_DELAY_OFS, 32'h3, "delay");
    wr(`RB_CMD_OFS, 32'h0143);
    wait_bit(1, 1'b1);
    fork
      wr(`RB_CMD_OFS, 32'h0243);
      wait_bit(2, 1'b1);
    join
    check("delay_gap", {31'h0, n >= 3 * MS - 1 && n <= 3 * MS + 6}, 32'h1);
    // dwell reopens a closed relay
    wr(`RB_DELAY_OFS, 32'h0);
    wr(`RB_DWELL_OFS, 32'h2);
    rd(`RB_DWELL_OFS, 32'h2, "dwell");
    wr(`RB_CMD_OFS, 32'h0743);
    wait_bit(7, 1'b1);
    wait_bit(7, 1'b0);
    check("dwell_time", {31'h0, n >= 2 * MS - 1 && n <= 2 * MS + 4}, 32'h1);
    // reset bit: ignored with halt off, full reset with halt on
    wr(`RB_DWELL_OFS, 32'h0);
    wr(`RB_DELAY_OFS, 32'h5);
    wr(`RB_CMD_OFS, 32'h0343);
    wait_bit(3, 1'b1);
    wr(`RB_CTRL_OFS, 32'h1);
    repeat (4) @(posedge mclk);
    rd(`RB_DELAY_OFS, 32'h5, "halt_off_delay");
    check("halt_off_relays", relays, 32'h0000000E);
    halt <= 1'b1;
    // let the lamp stretch of the last halt-off access run out its checks before the reset
    repeat (4) @(posedge mclk);
    rd(`RB_CTRL_OFS, 32'h2, "halt_readback");
    wr(`RB_CTRL_OFS, 32'h1);
    repeat (6) @(posedge mclk);
    rd(`RB_DELAY_OFS, 32'h0, "halt_on_delay");
    check("halt_on_relays", relays, 32'h0);
    // unknown command character flags an error; writing the flag bit clears it
    wr(`RB_CMD_OFS, 32'h0058);
    rd(`RB_STAT_OFS, 32'h14, "status_err");
    wr(`RB_STAT_OFS, 32'h4);
    rd(`RB_STAT_OFS, 32'h10, "status_clear");
    halt <= 1'b0;
    // message lamp stretch and restart
    repeat (LAMP + 5) @(posedge mclk);
    check("lamp_idle", {31'h0, msg_lamp}, 32'h0);
    for (ch = 0; ch < 4; ch++) begin
      rd(`RB_DELAY_OFS, 32'h0, "lamp_poll");
      repeat (LAMP - 8) @(posedge mclk);
      check("lamp_held", {31'h0, msg_lamp}, 32'h1);
    end
    la <= 8'h00;
    acc(1'b0, BASE, 32'h0);
    check("la_zero", {31'h0, e}, 32'h1);
    tally_and_finish();
  end
endmodule
